// [rtl/eesr_ecc_err_report.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - status read returns 16-bit word for unit
// - bit 0 shows correction off for unit
// - bit 1 data fix, bit 2 code error
// - bit 3 sticky single fix, cleared on exit
// - bit 4 sticky double detect, cleared on exit
// - sticky bits ignore the unit address
// - reset or overlay exit zeroes status word
// - trap first enabled error type, density dependent
// - trap valid only while bit 3 or 4
// - first failing half-page kept until re-armed
// - every exit clears traps and sticky bits
// - half-page granularity, unused address bits zero
// - multi-programmed half-page without detect is unchecked
// - count main array errors outside overlays only
// - counter saturates, never wraps
// - counter cleared by reset or clear command
// - counter commands act only inside overlay
// - one count per failing half-page read
// - keep counting while strobe stalled, until deselect
// - double detect holds strobe low if enabled
module eesr_ecc_err_report #(
  parameter eesr_pkg::eesr_density_t DENSITY = eesr_pkg::DENS_256
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // chip select pin, active low, asynchronous to i_sys_clk
  input wire logic i_cs_n,
  // half-page check result from the decode datapath, one-cycle pulse
  input wire logic i_hp_valid,
  input wire logic [eesr_pkg::ADDR_W-1:0] i_hp_addr,
  input wire logic i_hp_single,
  input wire logic i_hp_check_err,
  input wire logic i_hp_double,
  input wire logic i_hp_correction_off,
  input wire logic i_hp_multi_prog,
  // overlay state from the command decoder
  input wire logic i_status_overlay,
  input wire logic i_any_overlay,
  input wire logic i_overlay_exit,
  input wire logic i_double_error_detect_en,
  // configuration registers
  input wire logic [eesr_pkg::WORD_W-1:0] i_protection_config_reg,
  input wire logic [eesr_pkg::WORD_W-1:0] i_volatile_config_reg,
  // overlay command port
  input wire logic i_cmd_valid,
  input wire eesr_pkg::eesr_cmd_t i_cmd,
  output logic o_rvalid,
  output logic [eesr_pkg::WORD_W-1:0] o_rdata,
  // either sticky bit set; trap stays empty if only non-trapping single errors occurred
  output logic o_trap_valid,
  // hold the read strobe low
  output logic o_read_strobe_stall
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    logic cs_n_meta;                            // first sync stage
    logic cs_n_sync;                            // second sync stage
    logic single_bit_fixed_seen;                // sticky, global
    logic double_bit_seen;                      // sticky, global
    logic trap_full;                            // capture done, no re-arm yet
    logic [eesr_pkg::WORD_W-1:0] trap_lo;       // error_address_low_trap
    logic [eesr_pkg::WORD_W-1:0] trap_hi;       // error_address_high_trap
    logic [eesr_pkg::WORD_W-1:0] rdata;         // read answer
    logic rvalid;                               // answer strobe
    logic stall;                                // strobe held low
  } eesr_state_t;

  // deselected chip select after reset, everything else zero
  localparam eesr_state_t RESET_STATE = '{
    cs_n_meta: 1'b1,
    cs_n_sync: 1'b1,
    default: '0
  };

  eesr_state_t st_q; // registered state
  eesr_state_t st_d; // next state

  // ========================================================================
  // helpers
  // ========================================================================
  // valid upper address bits per density
  function automatic logic [eesr_pkg::WORD_W-1:0] hi_mask(
    input eesr_pkg::eesr_density_t dens
  );
    logic [eesr_pkg::WORD_W-1:0] m;
    m = eesr_pkg::HI_MASK_256;
    case (dens)
      eesr_pkg::DENS_128: m = eesr_pkg::HI_MASK_128;
      eesr_pkg::DENS_512: m = eesr_pkg::HI_MASK_512;
      default: m = eesr_pkg::HI_MASK_256;
    endcase
    return m;
  endfunction

  // the largest density has no counter and traps only double errors
  localparam logic IS_LARGEST = (DENSITY == eesr_pkg::DENS_512);
  localparam logic [eesr_pkg::WORD_W-1:0] HI_MASK = hi_mask(DENSITY);

  // ========================================================================
  // event qualification
  // ========================================================================
  logic hp_checked;    // half-page really went through checking
  logic err_single;    // single-bit fix in data or check code
  logic err_double;    // double-bit detection
  logic trap_both;     // single errors also trap
  logic trap_hit;      // error of an enabled trap type
  logic cnt_inc;       // counter step
  logic cmd_ok;        // command accepted
  logic cnt_clr;       // counter clear accepted
  logic stall_en;      // stall mode on
  logic [eesr_pkg::WORD_W-1:0] cnt_value; // counter contents

  assign hp_checked = i_hp_valid && !(i_hp_multi_prog && !i_double_error_detect_en);
  assign err_single = hp_checked && (i_hp_single || i_hp_check_err);
  assign err_double = hp_checked && i_hp_double;

  assign trap_both = !IS_LARGEST && i_protection_config_reg[eesr_pkg::PROT_TRAP_BOTH_BIT];
  assign trap_hit = err_double || (trap_both && err_single);

  // datapath pulses once per half-page read
  // counting runs on while the strobe is stalled
  assign cnt_inc = !IS_LARGEST && !i_any_overlay && !i_status_overlay
                   && (err_single || err_double);

  assign cmd_ok = i_cmd_valid && i_status_overlay;
  assign cnt_clr = cmd_ok && (i_cmd == eesr_pkg::CMD_CNT_CLEAR);

  // low bit means stall enabled
  assign stall_en = !i_volatile_config_reg[eesr_pkg::VCFG_STALL_OFF_BIT];

  // ========================================================================
  // error counter
  // ========================================================================
  // reset or clear command only
  eesr_sat_counter eesr_sat_counter_inst (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_inc(cnt_inc),
    .i_clr(cnt_clr),
    .o_count(cnt_value)
  );

  // ========================================================================
  // next state
  // ========================================================================
  // sets are applied after clears, so an event in an exit cycle survives
  always_comb begin
    st_d = st_q;
    // two-stage chip select synchroniser
    st_d.cs_n_meta = i_cs_n;
    st_d.cs_n_sync = st_q.cs_n_meta;
    st_d.rvalid = 1'b0;

    // exit clears traps and sticky bits
    if (i_overlay_exit) begin
      st_d.single_bit_fixed_seen = 1'b0;
      st_d.double_bit_seen = 1'b0;
      st_d.trap_full = 1'b0;
      st_d.trap_lo = '0;
      st_d.trap_hi = '0;
      st_d.rdata = eesr_pkg::STATUS_RESET;
    end

    if (err_single) begin
      st_d.single_bit_fixed_seen = 1'b1;
    end
    if (err_double) begin
      st_d.double_bit_seen = 1'b1;
    end

    if (trap_hit && !st_d.trap_full) begin
      st_d.trap_full = 1'b1;
      st_d.trap_lo = '0;
      st_d.trap_lo[eesr_pkg::LO_ADDR_MSB:eesr_pkg::LO_ADDR_LSB] =
        i_hp_addr[eesr_pkg::LO_ADDR_MSB:eesr_pkg::LO_ADDR_LSB];
      st_d.trap_hi = {{(eesr_pkg::WORD_W - eesr_pkg::HI_ADDR_W){1'b0}},
                      i_hp_addr[eesr_pkg::ADDR_W-1:eesr_pkg::HI_ADDR_LSB]} & HI_MASK;
    end

    if (st_q.cs_n_sync) begin
      st_d.stall = 1'b0;
    end else if (err_double && stall_en) begin
      st_d.stall = 1'b1;
    end

    if (cmd_ok && !i_overlay_exit) begin
      if (i_cmd == eesr_pkg::CMD_STATUS_READ) begin
        st_d.rvalid = 1'b1;
        st_d.rdata = eesr_pkg::STATUS_RESET;
        st_d.rdata[eesr_pkg::ST_OFF_BIT] = i_hp_valid && i_hp_correction_off;
        st_d.rdata[eesr_pkg::ST_UNIT_FIX_BIT] = hp_checked && i_hp_single;
        st_d.rdata[eesr_pkg::ST_CHECK_BIT] = hp_checked && i_hp_check_err;
        // current read already folded into sticky bits
        st_d.rdata[eesr_pkg::ST_FIX_BIT] = st_d.single_bit_fixed_seen;
        st_d.rdata[eesr_pkg::ST_DBL_BIT] = st_d.double_bit_seen;
      end else if (i_cmd == eesr_pkg::CMD_TRAP_LO_READ) begin
        st_d.rvalid = 1'b1;
        st_d.rdata = st_q.trap_lo;
      end else if (i_cmd == eesr_pkg::CMD_TRAP_HI_READ) begin
        st_d.rvalid = 1'b1;
        st_d.rdata = st_q.trap_hi;
      end else if (i_cmd == eesr_pkg::CMD_CNT_READ) begin
        // largest density has no counter, reads zero
        st_d.rvalid = 1'b1;
        st_d.rdata = IS_LARGEST ? eesr_pkg::CNT_ZERO : cnt_value;
      end else begin
        // clear command or unknown code: no answer
        st_d.rvalid = 1'b0;
      end
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  // clock enable low freezes the synchroniser too
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= RESET_STATE;
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign o_rvalid = st_q.rvalid;
  assign o_rdata = st_q.rdata;
  assign o_trap_valid = st_q.single_bit_fixed_seen || st_q.double_bit_seen;
  assign o_read_strobe_stall = st_q.stall;

  // ========================================================================
  // checks
  // ========================================================================
  default clocking clk_blk @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  AST_STATUS_ANSWER: assert property (
    (i_clk_en && cmd_ok && !i_overlay_exit && (i_cmd == eesr_pkg::CMD_STATUS_READ)) |=>
      (o_rvalid && (o_rdata[eesr_pkg::ST_DBL_BIT] == st_q.double_bit_seen)
       && (o_rdata[eesr_pkg::ST_FIX_BIT] == st_q.single_bit_fixed_seen))
  ) else $error("status read answer wrong");

  AST_OFF_BIT: assert property (
    (i_clk_en && cmd_ok && !i_overlay_exit && (i_cmd == eesr_pkg::CMD_STATUS_READ)
     && i_hp_valid && i_hp_correction_off) |=> o_rdata[eesr_pkg::ST_OFF_BIT]
  ) else $error("correction off bit missing");

  AST_DBL_STICKY: assert property (
    (i_clk_en && err_double) |=> st_q.double_bit_seen
      ##1 (st_q.double_bit_seen || $past(i_overlay_exit))
  ) else $error("double detect flag lost");

  AST_EXIT_CLEARS: assert property (
    (i_clk_en && i_overlay_exit && !err_single && !err_double) |=>
      (!st_q.single_bit_fixed_seen && !st_q.double_bit_seen && !st_q.trap_full
       && (st_q.trap_lo == '0) && (st_q.trap_hi == '0) && !o_trap_valid)
  ) else $error("overlay exit left state behind");

  AST_TRAP_HOLD: assert property (
    (i_clk_en && st_q.trap_full && !i_overlay_exit) |=>
      ($stable(st_q.trap_lo) && $stable(st_q.trap_hi))
  ) else $error("trap overwritten");

  AST_TRAP_SHAPE: assert property (
    (st_q.trap_lo[eesr_pkg::LO_ADDR_LSB-1:0] == '0) && ((st_q.trap_hi & ~HI_MASK) == '0)
  ) else $error("trap holds bits outside the address");

  AST_UNCHECKED: assert property (
    (i_clk_en && i_hp_valid && i_hp_multi_prog && !i_double_error_detect_en
     && !st_q.trap_full) |=> !st_q.trap_full
  ) else $error("unchecked half-page trapped");

  AST_NO_COUNT_IN_OVERLAY: assert property (
    (i_clk_en && (i_any_overlay || i_status_overlay) && !cnt_clr) |=> $stable(cnt_value)
  ) else $error("counter moved inside an overlay");

  AST_EXIT_KEEPS_COUNT: assert property (
    (i_clk_en && i_overlay_exit && !cnt_inc && !cnt_clr) |=> $stable(cnt_value)
  ) else $error("overlay exit touched the counter");

  AST_STALL_HOLD: assert property (
    (i_clk_en && o_read_strobe_stall && !st_q.cs_n_sync) |=> o_read_strobe_stall
  ) else $error("stall released while selected");

  AST_STALL_CAUSE: assert property (
    $rose(o_read_strobe_stall) |-> $past(err_double && stall_en && !st_q.cs_n_sync)
  ) else $error("stall without an enabled double detect");

  COV_STATUS_READ: cover property (
    o_rvalid && o_rdata[eesr_pkg::ST_DBL_BIT]
  );
  COV_STALL: cover property (
    $rose(o_read_strobe_stall) ##[1:100] $fell(o_read_strobe_stall)
  );
  COV_TRAP_THEN_EXIT: cover property (
    $rose(st_q.trap_full) ##[1:50] i_overlay_exit
  );

endmodule
`default_nettype wire

// [rtl/eesr_sat_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// saturating error event counter
// ==========================================================================
module eesr_sat_counter (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [eesr_pkg::WORD_W-1:0] o_count
);

  // whole state of the counter
  typedef struct packed {
    logic [eesr_pkg::WORD_W-1:0] count;
  } eesr_cnt_state_t;

  eesr_cnt_state_t st_q; // registered state
  eesr_cnt_state_t st_d; // next state

  // ========================================================================
  // next state
  // ========================================================================
  // clear then increment, so an error in the clear cycle is still counted
  always_comb begin
    st_d = st_q;
    if (i_clr) begin
      st_d.count = eesr_pkg::CNT_ZERO;
    end
    if (i_inc && (st_d.count != eesr_pkg::CNT_MAX)) begin
      st_d.count = st_d.count + eesr_pkg::CNT_ONE;
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  // reset covers power-on and hardware reset alike
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  assign o_count = st_q.count;

  // ========================================================================
  // checks
  // ========================================================================
  default clocking clk_blk @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  AST_CNT_SATURATES: assert property (
    (i_clk_en && i_inc && !i_clr && (o_count == eesr_pkg::CNT_MAX)) |=>
      (o_count == eesr_pkg::CNT_MAX)
  ) else $error("counter wrapped past its maximum");

  // an error in the clear cycle still counts, so the result is one, not zero
  AST_CNT_CLEARS: assert property (
    (i_clk_en && i_clr) |=>
      (o_count == ($past(i_inc) ? eesr_pkg::CNT_ONE : eesr_pkg::CNT_ZERO))
  ) else $error("counter clear did not take");

  AST_CNT_STEP: assert property (
    (i_clk_en && i_inc && !i_clr && (o_count != eesr_pkg::CNT_MAX)) |=>
      (o_count == $past(o_count) + eesr_pkg::CNT_ONE)
  ) else $error("counter missed one error");

endmodule
`default_nettype wire

// [shared/eesr_pkg.sv]
// ==========================================================================
// shared constants for the ecc error reporting block
// ==========================================================================
package eesr_pkg;

  // ========================================================================
  // widths
  // ========================================================================
  localparam int ADDR_W = 25;                 // word address, bits 24..0
  localparam int WORD_W = 16;                 // register and counter width
  localparam int HI_ADDR_W = ADDR_W - 16;     // address bits held in upper trap

  // ========================================================================
  // status word layout and reset value
  // ========================================================================
  localparam int ST_OFF_BIT = 0;              // correction_off
  localparam int ST_UNIT_FIX_BIT = 1;         // unit_data_corrected
  localparam int ST_CHECK_BIT = 2;            // check_code_error
  localparam int ST_FIX_BIT = 3;              // single_bit_fixed_seen
  localparam int ST_DBL_BIT = 4;              // double_bit_seen
  localparam int ST_RSV_W = WORD_W - ST_DBL_BIT - 1; // reserved bits, read as zero
  localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;

  // ========================================================================
  // trap register layout
  // ========================================================================
  localparam int LO_ADDR_MSB = 15;            // lower trap holds A15..A3
  localparam int LO_ADDR_LSB = 3;             // half-page granularity
  localparam int HI_ADDR_LSB = 16;            // upper trap starts at A16
  localparam logic [WORD_W-1:0] HI_MASK_128 = 16'h007f;
  localparam logic [WORD_W-1:0] HI_MASK_256 = 16'h00ff;
  localparam logic [WORD_W-1:0] HI_MASK_512 = 16'h01ff;

  // ========================================================================
  // configuration register bits
  // ========================================================================
  localparam int PROT_TRAP_BOTH_BIT = 13;     // protection_config_reg
  localparam int VCFG_STALL_OFF_BIT = 2;      // volatile_config_reg

  // ========================================================================
  // counter limit
  // ========================================================================
  localparam logic [WORD_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [WORD_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] CNT_ZERO = 16'h0000;

  // ========================================================================
  // enumerations
  // ========================================================================
  typedef enum logic [1:0] {
    DENS_128 = 2'h0,
    DENS_256 = 2'h1,
    DENS_512 = 2'h2
  } eesr_density_t;

  typedef enum logic [2:0] {
    CMD_STATUS_READ = 3'h0,
    CMD_TRAP_LO_READ = 3'h1,
    CMD_TRAP_HI_READ = 3'h2,
    CMD_CNT_READ = 3'h3,
    CMD_CNT_CLEAR = 3'h4
  } eesr_cmd_t;

endpackage

// [test/eesr_ecc_err_report_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench: array errors, overlay reads, stall and counter
// ==========================================================================
module eesr_ecc_err_report_tb;
  // error flags {multi, off, double, check, single}
  localparam logic [4:0] SGL = 5'h01;
  localparam logic [4:0] CHK = 5'h02;
  localparam logic [4:0] DBL = 5'h04;
  localparam logic [4:0] OFF = 5'h08;
  localparam logic [4:0] MUL = 5'h10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic cs_n = 1'b1;
  logic hp_valid = 1'b0;
  logic [24:0] hp_addr = 25'h0;
  logic hp_single = 1'b0;
  logic hp_check = 1'b0;
  logic hp_double = 1'b0;
  logic hp_off = 1'b0;
  logic hp_multi = 1'b0;
  logic any_ov = 1'b0;
  logic ded_en = 1'b1;
  logic [15:0] prot_cfg = 16'h2000; // single errors trap too
  logic [15:0] vol_cfg = 16'h0000; // stall enabled
  logic st_ov, ov_exit, cmd_valid, rvalid, trap_valid, stall, bus_err;
  eesr_pkg::eesr_cmd_t cmd;
  logic [15:0] rdata;
  int fail_count = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  eesr_ecc_err_report #(.DENSITY(eesr_pkg::DENS_256)) eesr_ecc_err_report_inst (
    .i_sys_clk(clk), .i_reset(reset), .i_clk_en(clk_en), .i_cs_n(cs_n),
    .i_hp_valid(hp_valid), .i_hp_addr(hp_addr), .i_hp_single(hp_single),
    .i_hp_check_err(hp_check), .i_hp_double(hp_double),
    .i_hp_correction_off(hp_off), .i_hp_multi_prog(hp_multi),
    .i_status_overlay(st_ov), .i_any_overlay(any_ov), .i_overlay_exit(ov_exit),
    .i_double_error_detect_en(ded_en), .i_protection_config_reg(prot_cfg),
    .i_volatile_config_reg(vol_cfg), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_rvalid(rvalid), .o_rdata(rdata), .o_trap_valid(trap_valid),
    .o_read_strobe_stall(stall));
  eesr_host_model eesr_host_model_inst (
    .i_sys_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .i_stall(stall),
    .o_overlay(st_ov), .o_exit(ov_exit), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_bus_error(bus_err));
  // word compare, flags are zero extended
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one half-page result from the array, then a quiet cycle
  task automatic ev(input logic [24:0] a, input logic [4:0] f);
    {hp_multi, hp_off, hp_double, hp_check, hp_single} = f;
    hp_addr = a;
    hp_valid = 1'b1;
    @(negedge clk);
    hp_valid = 1'b0;
    @(negedge clk);
  endtask
  // overlay read; a status read carries its unit result alongside
  task automatic rd(input eesr_pkg::eesr_cmd_t c, input logic [4:0] f,
                    input logic want_ok, input logic [15:0] exp);
    logic ok;
    logic [15:0] d;
    {hp_multi, hp_off, hp_double, hp_check, hp_single} = f;
    hp_addr = 25'h0000010;
    hp_valid = (c == eesr_pkg::CMD_STATUS_READ);
    eesr_host_model_inst.send(c, ok, d);
    hp_valid = 1'b0;
    check({15'h0, ok}, {15'h0, want_ok});
    if (want_ok) begin
      check(d, exp);
    end
    @(negedge clk);
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence, all changes at falling edges
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    eesr_host_model_inst.enter();
    rd(eesr_pkg::CMD_STATUS_READ, 5'h0, 1'b1, 16'h0000);
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b1, 16'h0000);
    rd(eesr_pkg::CMD_STATUS_READ, OFF, 1'b1, 16'h0001);
    rd(eesr_pkg::CMD_STATUS_READ, SGL, 1'b1, 16'h000a);
    rd(eesr_pkg::CMD_STATUS_READ, CHK, 1'b1, 16'h000c);
    check({15'h0, trap_valid}, 16'h0001);
    eesr_host_model_inst.leave();
    cs_n = 1'b0;
    repeat (3) @(negedge clk);
    ev(25'h1abcdef, SGL);
    ev(25'h0000100, DBL);
    check({15'h0, stall}, 16'h0001);
    ev(25'h1abcdef, SGL);
    repeat (40) @(negedge clk);
    check({15'h0, bus_err}, 16'h0001);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    check({15'h0, stall}, 16'h0000);
    // unchecked and overlaid reads are not counted
    ded_en = 1'b0;
    ev(25'h0000200, MUL | DBL);
    ded_en = 1'b1;
    any_ov = 1'b1;
    ev(25'h0000300, SGL);
    any_ov = 1'b0;
    vol_cfg = 16'h0004;
    cs_n = 1'b0;
    repeat (3) @(negedge clk);
    ev(25'h0000400, DBL);
    check({15'h0, stall}, 16'h0000);
    cs_n = 1'b1;
    // clock enable low: this error must leave no trace in the count
    clk_en = 1'b0;
    ev(25'h0000500, DBL);
    clk_en = 1'b1;
    // first trap kept, counts add up
    eesr_host_model_inst.enter();
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b1, 16'h0004);
    rd(eesr_pkg::CMD_TRAP_LO_READ, 5'h0, 1'b1, 16'hcde8);
    rd(eesr_pkg::CMD_TRAP_HI_READ, 5'h0, 1'b1, 16'h00ab);
    rd(eesr_pkg::CMD_STATUS_READ, 5'h0, 1'b1, 16'h0010);
    eesr_host_model_inst.leave();
    // exit clears, counter kept, commands refused outside
    rd(eesr_pkg::CMD_CNT_CLEAR, 5'h0, 1'b0, 16'h0000);
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b0, 16'h0000);
    check({15'h0, trap_valid}, 16'h0000);
    eesr_host_model_inst.enter();
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b1, 16'h0004);
    rd(eesr_pkg::CMD_STATUS_READ, 5'h0, 1'b1, 16'h0000);
    rd(eesr_pkg::CMD_TRAP_LO_READ, 5'h0, 1'b1, 16'h0000);
    eesr_host_model_inst.leave();
    // single errors skip the trap when not enabled
    prot_cfg = 16'h0000;
    ev(25'h0054321, SGL);
    ev(25'h0012345, DBL);
    eesr_host_model_inst.enter();
    rd(eesr_pkg::CMD_TRAP_LO_READ, 5'h0, 1'b1, 16'h2340);
    rd(eesr_pkg::CMD_TRAP_HI_READ, 5'h0, 1'b1, 16'h0001);
    rd(eesr_pkg::CMD_CNT_CLEAR, 5'h0, 1'b0, 16'h0000);
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b1, 16'h0000);
    eesr_host_model_inst.leave();
    // counter saturates, one event every cycle
    {hp_multi, hp_off, hp_double, hp_check, hp_single} = SGL;
    hp_valid = 1'b1;
    repeat (65540) @(negedge clk);
    hp_valid = 1'b0;
    eesr_host_model_inst.enter();
    rd(eesr_pkg::CMD_CNT_READ, 5'h0, 1'b1, 16'hffff);
    complete_run();
  end
endmodule
`default_nettype wire

// [test/eesr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host side: overlay control, command port, strobe watchdog
// ==========================================================================
module eesr_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rvalid,
  input wire logic [eesr_pkg::WORD_W-1:0] i_rdata,
  input wire logic i_stall,
  output logic o_overlay,
  output logic o_exit,
  output logic o_cmd_valid,
  output var eesr_pkg::eesr_cmd_t o_cmd,
  output logic o_bus_error
);
  int stall_cycles; // cycles the strobe has stood still
  // idle host: no overlay, no request
  initial begin
    o_overlay = 1'b0;
    o_exit = 1'b0;
    o_cmd_valid = 1'b0;
    o_cmd = eesr_pkg::CMD_STATUS_READ;
  end
  always_ff @(posedge i_sys_clk) begin
    stall_cycles <= i_stall ? stall_cycles + 1 : 0;
  end
  assign o_bus_error = (stall_cycles > 32);
  task automatic enter();
    o_overlay = 1'b1;
    @(negedge i_sys_clk);
  endtask
  // exit pulse, then back to array reads
  task automatic leave();
    o_exit = 1'b1;
    @(negedge i_sys_clk);
    o_exit = 1'b0;
    o_overlay = 1'b0;
    @(negedge i_sys_clk);
  endtask
  // one command, caller sits at a falling edge; answer lands one cycle on
  task automatic send(input eesr_pkg::eesr_cmd_t c, output logic ok,
                      output logic [eesr_pkg::WORD_W-1:0] d);
    o_cmd = c;
    o_cmd_valid = 1'b1;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    ok = i_rvalid;
    d = i_rdata;
    // reserved bits, and bits 3..1 after a double, are don't care
    if (c == eesr_pkg::CMD_STATUS_READ) begin
      d = d & (d[4] ? 16'h0011 : 16'h001f);
    end
  endtask
endmodule
`default_nettype wire
